// ---- design/tmw_pkg.sv ----
// Package for the 8-bit timer waveform mode control block.
// Assumes a single 50 MHz clock domain and a plain register port.
package tmw_pkg;

   // ***********************************************
   // Register map and fields
   // ***********************************************
   localparam logic [7:0] TMW_OFS_MODE_CTRL  = 8'hB0;
   localparam logic [7:0] TMW_OFS_CLK_FORCE  = 8'hB1;
   localparam logic [7:0] TMW_OFS_CMP_A      = 8'hB3;
   localparam logic [7:0] TMW_OFS_CMP_B      = 8'hB4;
   localparam logic [7:0] TMW_OFS_COUNT      = 8'hB2;
   localparam logic [7:0] TMW_OFS_PIN_CTRL   = 8'hB5;
   localparam logic [7:0] TMW_OFS_STATUS     = 8'hB6;
   localparam logic [7:0] TMW_RESET_VALUE    = 8'h00;
   localparam logic [7:0] TMW_MODE_CTRL_MASK = 8'hF3;
   localparam logic [7:0] TMW_CLK_FORCE_MASK = 8'h0F;
   localparam int         TMW_FOC_A_BIT      = 7;
   localparam int         TMW_FOC_B_BIT      = 6;
   localparam int         TMW_TOPSEL_BIT     = 3;

   // ***********************************************
   // Counter constants
   // ***********************************************
   localparam logic [7:0] TMW_MAX    = 8'hFF;
   localparam logic [7:0] TMW_BOTTOM = 8'h00;

   // Waveform modes
   localparam logic [2:0] TMW_WM_NORMAL  = 3'h0;
   localparam logic [2:0] TMW_WM_PC_FF   = 3'h1;
   localparam logic [2:0] TMW_WM_CTC     = 3'h2;
   localparam logic [2:0] TMW_WM_FAST_FF = 3'h3;
   localparam logic [2:0] TMW_WM_PC_A    = 3'h5;
   localparam logic [2:0] TMW_WM_FAST_A  = 3'h7;

   // Output actions
   localparam logic [1:0] TMW_ACT_NONE   = 2'h0;
   localparam logic [1:0] TMW_ACT_TOGGLE = 2'h1;
   localparam logic [1:0] TMW_ACT_CLEAR  = 2'h2;
   localparam logic [1:0] TMW_ACT_SET    = 2'h3;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tmw_bus_s;

   typedef struct packed {
      logic [7:0] top;
      logic       dual_slope;
      logic       pwm;
      logic       fast;
      logic       upd_at_top;
      logic       upd_at_bottom;
      logic       ovf_at_top;
      logic       ovf_at_bottom;
   } tmw_mode_s;

endpackage : tmw_pkg

// ---- design/tmw_prescaler.sv ----
// Clock-select prescaler: one-cycle count enable pulses.
// Assumes the single system clock mclk with synchronous active-low reset.
`timescale 1ns/100ps
module tmw_prescaler (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [2:0] clock_select,
   output logic            tick
);
   import tmw_pkg::*;

   logic [9:0] div_q;
   logic [9:0] div_d;
   logic       tick_d;

   always_comb begin
      div_d  = div_q + 10'h001;
      tick_d = 1'b0;
      case (clock_select)
         3'h0:    tick_d = 1'b0;
         3'h1:    tick_d = 1'b1;
         3'h2:    tick_d = (div_q[2:0] == 3'h7);
         3'h3:    tick_d = (div_q[4:0] == 5'h1F);
         3'h4:    tick_d = (div_q[5:0] == 6'h3F);
         3'h5:    tick_d = (div_q[6:0] == 7'h7F);
         3'h6:    tick_d = (div_q[7:0] == 8'hFF);
         3'h7:    tick_d = (div_q == 10'h3FF);
         default: tick_d = 1'b0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_q <= 10'h000;
         tick  <= 1'b0;
      end else begin
         div_q <= div_d;
         tick  <= tick_d;
      end
   end

   div_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (clock_select == 3'h0) ##1 (clock_select == 3'h0) |-> !tick)
      else $error("tick while stopped");
   div_full_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (clock_select == 3'h1) |=> tick)
      else $error("no tick when undivided");

endmodule : tmw_prescaler

// ---- design/tmw_mode_decode.sv ----
// Decoder from the 3-bit waveform mode to counting properties.
// Purely combinational; the caller registers what it needs.
`timescale 1ns/100ps
module tmw_mode_decode (
   input  wire logic [2:0] waveform_mode,
   input  wire logic [7:0] compare_value_a,
   output tmw_pkg::tmw_mode_s mode
);
   import tmw_pkg::*;

   always_comb begin
      mode     = '0;
      mode.top = TMW_MAX;
      case (waveform_mode)
         TMW_WM_NORMAL: begin
            mode.ovf_at_top = 1'b1;
         end
         TMW_WM_PC_FF: begin
            mode.dual_slope    = 1'b1;
            mode.pwm           = 1'b1;
            mode.upd_at_top    = 1'b1;
            mode.ovf_at_bottom = 1'b1;
         end
         TMW_WM_CTC: begin
            mode.top        = compare_value_a;
            mode.ovf_at_top = 1'b0;
         end
         TMW_WM_FAST_FF: begin
            mode.pwm           = 1'b1;
            mode.fast          = 1'b1;
            mode.upd_at_bottom = 1'b1;
            mode.ovf_at_top    = 1'b1;
         end
         TMW_WM_PC_A: begin
            mode.top           = compare_value_a;
            mode.dual_slope    = 1'b1;
            mode.pwm           = 1'b1;
            mode.upd_at_top    = 1'b1;
            mode.ovf_at_bottom = 1'b1;
         end
         TMW_WM_FAST_A: begin
            mode.top           = compare_value_a;
            mode.pwm           = 1'b1;
            mode.fast          = 1'b1;
            mode.upd_at_bottom = 1'b1;
            mode.ovf_at_top    = 1'b1;
         end
         // Reserved modes 4 and 6 fall back to normal counting
         default: mode.ovf_at_top = 1'b1;
      endcase
   end

endmodule : tmw_mode_decode

// ---- design/tmw_timer.sv ----
// ***********************************************
// Timer waveform mode control: registers, counter, two waveform pins
// ***********************************************
// Functional notes
// - Nonzero output mode routes waveform to pin; the code keeps pin A on the port for PWM mode 01 without topselect
// - Driver enabled only when direction bit set
// - Non-PWM channel A: off, toggle, clear, set
// - Non-PWM channel B decodes like channel A
// - Fast PWM A: clear/set at match, BOTTOM
// - PWM A mode 01 toggles only if topselect
// - Fast PWM compare at TOP acts at BOTTOM
// - Phase-correct A: action depends on direction
// - Phase-correct compare at TOP acts at TOP
// - Fast PWM B: 01 reserved, else like A
// - Phase-correct B: 01 reserved, else like A
// - Control bits 3,2 read as zero
// - Mode = topselect plus two low bits
// - Mode 0 normal, TOP FF, immediate, MAX
// - Mode 1 phase-correct, FF, TOP, BOTTOM
// - Mode 2 CLEAR_ON_MATCH_MODE, TOP from A, immediate
// - Mode 3 fast, FF, BOTTOM, MAX
// - Mode 5 phase-correct, TOP from A
// - Mode 7 fast, TOP from A, flag at TOP
// - Force bit acts once, reads zero
// - Clock select stops or divides the clock
//
// Assumes inputs synchronous to mclk; read data valid the cycle after rd.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module tmw_timer (
   input  wire logic           mclk,
   input  wire logic           rst_n,
   input  wire logic [7:0]     reg_addr,
   input  wire logic [7:0]     reg_wdata,
   input  wire logic           reg_wr,
   input  wire logic           reg_rd,
   output logic [7:0]          reg_rdata,
   input  wire logic           port_out_a,
   input  wire logic           port_out_b,
   output logic                pin_out_a,
   output logic                pin_oe_n_a,
   output logic                pin_out_b,
   output logic                pin_oe_n_b,
   output logic                overflow_flag
);
   import tmw_pkg::*;

   // ***********************************************
   // Helper functions
   // ***********************************************
   function automatic logic apply_act(input logic cur, input logic [1:0] act);
      case (act)
         TMW_ACT_TOGGLE: apply_act = ~cur;
         TMW_ACT_CLEAR:  apply_act = 1'b0;
         TMW_ACT_SET:    apply_act = 1'b1;
         default:        apply_act = cur;
      endcase
   endfunction : apply_act

   // Action for a match (or the substituted event) in the current mode
   function automatic logic [1:0] match_act(input logic [1:0] com, input logic pwm,
                                            input logic fast, input logic down,
                                            input logic topsel, input logic chan_b);
      if (!pwm) begin
         match_act = com;
      end else if (com == 2'h1) begin
         match_act = (topsel && !chan_b) ? TMW_ACT_TOGGLE
                                         : TMW_ACT_NONE;
      end else if (com[1] && fast) begin
         match_act = com;
      end else if (com[1]) begin
         match_act = (com[0] ^ down) ? TMW_ACT_SET : TMW_ACT_CLEAR;
      end else begin
         match_act = TMW_ACT_NONE;
      end
   endfunction : match_act

   // ***********************************************
   // Registers
   // ***********************************************
   logic [7:0] mode_ctrl_q, mode_ctrl_d;
   logic [7:0] clk_force_q, clk_force_d;
   logic [7:0] cmp_a_buf_q, cmp_a_buf_d;
   logic [7:0] cmp_b_buf_q, cmp_b_buf_d;
   logic [7:0] cmp_a_q,     cmp_a_d;
   logic [7:0] cmp_b_q,     cmp_b_d;
   logic [7:0] pin_dir_q,   pin_dir_d;
   logic [7:0] rdata_d;
   logic       force_a, force_b;
   tmw_bus_s   bus;
   tmw_mode_s  mode;
   logic [2:0] waveform_mode;
   logic       tick;

   assign bus           = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign waveform_mode = {clk_force_q[TMW_TOPSEL_BIT], mode_ctrl_q[1:0]};
   assign force_a       = bus.wr && bus.addr == TMW_OFS_CLK_FORCE
                          && bus.wdata[TMW_FOC_A_BIT];
   assign force_b       = bus.wr && bus.addr == TMW_OFS_CLK_FORCE
                          && bus.wdata[TMW_FOC_B_BIT];

   tmw_mode_decode u_dec (
      .waveform_mode   (waveform_mode),
      .compare_value_a (cmp_a_q),
      .mode            (mode)
   );

   tmw_prescaler u_pre (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .clock_select (clk_force_q[2:0]),
      .tick         (tick)
   );

   // ***********************************************
   // Counter and waveform state
   // ***********************************************
   logic [7:0] count_q, count_d;
   logic       down_q,  down_d;
   logic       wave_a_q, wave_a_d;
   logic       wave_b_q, wave_b_d;
   logic       ovf_q,   ovf_d;
   logic       at_top, at_bottom, hit_a, hit_b, cnt_wr;

   always_comb begin
      mode_ctrl_d = mode_ctrl_q;
      clk_force_d = clk_force_q;
      cmp_a_buf_d = cmp_a_buf_q;
      cmp_b_buf_d = cmp_b_buf_q;
      pin_dir_d   = pin_dir_q;
      cnt_wr      = 1'b0;
      if (bus.wr) begin
         case (bus.addr)
            TMW_OFS_MODE_CTRL: mode_ctrl_d = bus.wdata & TMW_MODE_CTRL_MASK;
            TMW_OFS_CLK_FORCE: clk_force_d = bus.wdata & TMW_CLK_FORCE_MASK;
            TMW_OFS_CMP_A:     cmp_a_buf_d = bus.wdata;
            TMW_OFS_CMP_B:     cmp_b_buf_d = bus.wdata;
            TMW_OFS_PIN_CTRL:  pin_dir_d   = bus.wdata & 8'h03;
            TMW_OFS_COUNT:     cnt_wr      = 1'b1;
            default:           cnt_wr      = 1'b0;
         endcase
      end
      rdata_d = 8'h00;
      if (bus.rd) begin
         case (bus.addr)
            TMW_OFS_MODE_CTRL: rdata_d = mode_ctrl_q;
            TMW_OFS_CLK_FORCE: rdata_d = clk_force_q;
            TMW_OFS_CMP_A:     rdata_d = cmp_a_buf_q;
            TMW_OFS_CMP_B:     rdata_d = cmp_b_buf_q;
            TMW_OFS_COUNT:     rdata_d = count_q;
            TMW_OFS_PIN_CTRL:  rdata_d = pin_dir_q;
            TMW_OFS_STATUS:    rdata_d = {5'h00, wave_b_q, wave_a_q, ovf_q};
            default:           rdata_d = 8'h00;
         endcase
      end
   end

   assign at_top    = (count_q == mode.top);
   assign at_bottom = (count_q == TMW_BOTTOM);
   assign hit_a     = (count_q == cmp_a_q);
   assign hit_b     = (count_q == cmp_b_q);

   always_comb begin
      count_d  = count_q;
      down_d   = down_q;
      cmp_a_d  = cmp_a_q;
      cmp_b_d  = cmp_b_q;
      wave_a_d = wave_a_q;
      wave_b_d = wave_b_q;
      ovf_d    = 1'b0;
      // Immediate update in non-PWM modes, buffered otherwise
      if (!mode.pwm) begin
         cmp_a_d = cmp_a_buf_q;
         cmp_b_d = cmp_b_buf_q;
      end
      if (tick) begin
         if (mode.dual_slope) begin
            if (at_top) begin
               down_d  = 1'b1;
               count_d = count_q - 8'h01;
               if (mode.upd_at_top) begin
                  cmp_a_d = cmp_a_buf_q;
                  cmp_b_d = cmp_b_buf_q;
               end
            end else if (at_bottom && down_q) begin
               down_d  = 1'b0;
               count_d = count_q + 8'h01;
               ovf_d   = mode.ovf_at_bottom;
            end else begin
               count_d = down_q ? count_q - 8'h01 : count_q + 8'h01;
            end
            // Match at TOP acts as the down-count match, keeping the slope symmetric
            if (hit_a) begin
               wave_a_d = apply_act(wave_a_q, match_act(mode_ctrl_q[7:6], 1'b1,
                          1'b0, down_q || at_top, clk_force_q[TMW_TOPSEL_BIT], 1'b0));
            end
            if (hit_b) begin
               wave_b_d = apply_act(wave_b_q, match_act(mode_ctrl_q[5:4], 1'b1,
                          1'b0, down_q || at_top, 1'b0, 1'b1));
            end
         end else begin
            if (at_top) begin
               count_d = TMW_BOTTOM;
               ovf_d   = mode.ovf_at_top || count_q == TMW_MAX;
               if (mode.upd_at_bottom) begin
                  cmp_a_d = cmp_a_buf_q;
                  cmp_b_d = cmp_b_buf_q;
               end
            end else begin
               count_d = count_q + 8'h01;
               ovf_d   = !mode.ovf_at_top && count_q == TMW_MAX;
            end
            if (mode.fast) begin
               // Match at TOP ignored with upper bit set; action done at BOTTOM
               if (hit_a && !(at_top && mode_ctrl_q[7])) begin
                  wave_a_d = apply_act(wave_a_q, match_act(mode_ctrl_q[7:6], 1'b1,
                             1'b1, 1'b0, clk_force_q[TMW_TOPSEL_BIT], 1'b0));
               end else if (at_top && mode_ctrl_q[7]) begin
                  wave_a_d = ~mode_ctrl_q[6];
               end
               if (hit_b && !(at_top && mode_ctrl_q[5])) begin
                  wave_b_d = apply_act(wave_b_q, match_act(mode_ctrl_q[5:4], 1'b1,
                             1'b1, 1'b0, 1'b0, 1'b1));
               end else if (at_top && mode_ctrl_q[5]) begin
                  wave_b_d = ~mode_ctrl_q[4];
               end
            end else begin
               if (hit_a) begin
                  wave_a_d = apply_act(wave_a_q, mode_ctrl_q[7:6]);
               end
               if (hit_b) begin
                  wave_b_d = apply_act(wave_b_q, mode_ctrl_q[5:4]);
               end
            end
         end
      end else begin
         ovf_d = 1'b0;
      end
      // Forced match only in non-PWM modes; never touches counter or flag
      if (force_a && !mode.pwm) begin
         wave_a_d = apply_act(wave_a_q, mode_ctrl_q[7:6]);
      end
      if (force_b && !mode.pwm) begin
         wave_b_d = apply_act(wave_b_q, mode_ctrl_q[5:4]);
      end
      if (cnt_wr) begin
         count_d = bus.wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mode_ctrl_q <= TMW_RESET_VALUE;
         clk_force_q <= TMW_RESET_VALUE;
         cmp_a_buf_q <= TMW_RESET_VALUE;
         cmp_b_buf_q <= TMW_RESET_VALUE;
         cmp_a_q     <= TMW_RESET_VALUE;
         cmp_b_q     <= TMW_RESET_VALUE;
         pin_dir_q   <= TMW_RESET_VALUE;
         count_q     <= TMW_RESET_VALUE;
         down_q      <= 1'b0;
         wave_a_q    <= 1'b0;
         wave_b_q    <= 1'b0;
         ovf_q       <= 1'b0;
         reg_rdata   <= 8'h00;
      end else begin
         mode_ctrl_q <= mode_ctrl_d;
         clk_force_q <= clk_force_d;
         cmp_a_buf_q <= cmp_a_buf_d;
         cmp_b_buf_q <= cmp_b_buf_d;
         cmp_a_q     <= cmp_a_d;
         cmp_b_q     <= cmp_b_d;
         pin_dir_q   <= pin_dir_d;
         count_q     <= count_d;
         down_q      <= down_d;
         wave_a_q    <= wave_a_d;
         wave_b_q    <= wave_b_d;
         ovf_q       <= ovf_d;
         reg_rdata   <= rdata_d;
      end
   end

   // ***********************************************
   // Pin multiplexing
   // ***********************************************
   logic conn_a, conn_b;
   // Odd waveform codes are the PWM ones; mode 01 there needs top select on channel A only
   assign conn_a = |mode_ctrl_d[7:6]
                   && !(mode_ctrl_d[0] && mode_ctrl_d[7:6] == 2'h1
                        && !clk_force_d[TMW_TOPSEL_BIT]);
   assign conn_b = |mode_ctrl_d[5:4];

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pin_out_a     <= 1'b0;
         pin_out_b     <= 1'b0;
         pin_oe_n_a    <= 1'b1;
         pin_oe_n_b    <= 1'b1;
         overflow_flag <= 1'b0;
      end else begin
         pin_out_a     <= conn_a ? wave_a_d : port_out_a;
         pin_out_b     <= conn_b ? wave_b_d : port_out_b;
         pin_oe_n_a    <= ~pin_dir_d[0];
         pin_oe_n_b    <= ~pin_dir_d[1];
         overflow_flag <= ovf_d;
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   sequence force_write_s;
      reg_wr && reg_addr == TMW_OFS_CLK_FORCE;
   endsequence

   rsvd_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_rd && reg_addr == TMW_OFS_MODE_CTRL |=> reg_rdata[3:2] == 2'h0)
      else $error("reserved bits not zero");
   force_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
      force_write_s ##2 reg_rd && reg_addr == TMW_OFS_CLK_FORCE |=> reg_rdata[7:6] == 2'h0)
      else $error("force bits read nonzero");
   drv_dir_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !pin_dir_q[0] |-> pin_oe_n_a)
      else $error("driver on without direction");
   pin_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
      rst_n && mode_ctrl_q[7:6] == 2'h0 && !(reg_wr && reg_addr == TMW_OFS_MODE_CTRL)
      |=> pin_out_a == $past(port_out_a))
      else $error("port not routed when disconnected");
   mode_form_a: assert property (@(posedge mclk) disable iff (!rst_n)
      waveform_mode == TMW_WM_CTC |-> mode.top == cmp_a_q)
      else $error("CLEAR_ON_MATCH_MODE top wrong");
   top_ff_a: assert property (@(posedge mclk) disable iff (!rst_n)
      waveform_mode == TMW_WM_FAST_FF |-> mode.top == TMW_MAX && mode.upd_at_bottom)
      else $error("fast mode decode wrong");
   ovf_norm_a: assert property (@(posedge mclk) disable iff (!rst_n)
      tick && waveform_mode == TMW_WM_NORMAL && count_q == TMW_MAX && !cnt_wr
      |=> overflow_flag && count_q == TMW_BOTTOM)
      else $error("overflow at MAX missing");
   pc_ovf_a: assert property (@(posedge mclk) disable iff (!rst_n)
      tick && mode.dual_slope && down_q && at_bottom && !cnt_wr |=> ovf_q && !down_q)
      else $error("phase-correct flag missing at BOTTOM");
   nonpwm_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
      tick && !mode.pwm && hit_a && mode_ctrl_q[7:6] == TMW_ACT_SET |=> wave_a_q)
      else $error("set on match failed");

endmodule : tmw_timer

// ---- test/tmw_pin_load.sv ----
// Load on the two waveform pins: a pull-up on each line.
// Assumes active-low output enables from the timer block.
`timescale 1ns/100ps
module tmw_pin_load (
   input  wire logic pin_out_a,
   input  wire logic pin_oe_n_a,
   input  wire logic pin_out_b,
   input  wire logic pin_oe_n_b,
   output logic      level_a,
   output logic      level_b
);
   // ***********************************************
   // Line levels
   // ***********************************************
   // A released pin rises through the resistor, so a stale drive value never shows
   assign level_a = pin_oe_n_a ? 1'b1 : pin_out_a;
   assign level_b = pin_oe_n_b ? 1'b1 : pin_out_b;
endmodule : tmw_pin_load

// ---- test/tmw_timer_test.sv ----
// Self-checking bench for the timer waveform mode control block.
// Assumes the pull-up pin load model and a 50 MHz clock.
`timescale 1ns/100ps
module tmw_timer_test;
   import tmw_pkg::*;
   logic       mclk, rst_n, reg_wr, reg_rd, port_out_a, port_out_b;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       pin_out_a, pin_oe_n_a, pin_out_b, pin_oe_n_b, overflow_flag;
   logic       level_a, level_b;
   int         num_errors, total_checks, cycles, na, nb, nv;
   int         fc[4] = '{3, 2, 1, 1};
   int         fe[4] = '{1, 0, 1, 0};
   int         md[7] = '{0, 3, 1, 2, 5, 7, 3};
   int         cm[7] = '{'hE0, 'hE0, 'hE0, 'hE0, 'h20, 'h60, 'h60};
   int         ca[7] = '{'h80, 'h80, 'h80, 'h3F, 'h3F, 'h3F, 'h80};
   int         wn[7] = '{512, 512, 510, 512, 504, 512, 512};
   int         ov[7] = '{2, 2, 1, 0, 4, 8, 2};
   int         ha[7] = '{512, 254, 254, 512, 504, 256, 512};
   int         hb[7] = '{0, 66, 64, 0, 256, 264, 66};

   tmw_timer u_tmw_timer (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .port_out_a(port_out_a), .port_out_b(port_out_b), .pin_out_a(pin_out_a),
      .pin_oe_n_a(pin_oe_n_a), .pin_out_b(pin_out_b), .pin_oe_n_b(pin_oe_n_b),
      .overflow_flag(overflow_flag));
   tmw_pin_load u_tmw_pin_load (.pin_out_a(pin_out_a), .pin_oe_n_a(pin_oe_n_a),
      .pin_out_b(pin_out_b), .pin_oe_n_b(pin_oe_n_b), .level_a(level_a),
      .level_b(level_b));

   // ***********************************************
   // Tasks
   // ***********************************************
   task automatic summarize();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      @(posedge mclk);
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample mid-cycle
   task automatic rdx(input logic [7:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      @(negedge mclk);
      chk({8'h00, reg_rdata}, {8'h00, exp});
      @(posedge mclk);
   endtask : rdx

   task automatic meas(input int win);
      na = 0;
      nb = 0;
      nv = 0;
      repeat (win) begin
         @(negedge mclk);
         na += int'(level_a === 1'b1);
         nb += int'(level_b === 1'b1);
         nv += int'(overflow_flag === 1'b1);
         @(posedge mclk);
      end
   endtask : meas

   // ***********************************************
   // Clock, watchdog and sequence
   // ***********************************************
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Whole run is near 8000 cycles
   initial begin
      cycles = 0;
      forever @(posedge mclk) begin
         cycles++;
         if (cycles == 12000) begin
            num_errors++;
            summarize();
         end
      end
   end

   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      port_out_a = 1'b1;
      port_out_b = 1'b0;
      num_errors = 0;
      total_checks = 0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rdx(TMW_OFS_MODE_CTRL, TMW_RESET_VALUE);
      rdx(TMW_OFS_CLK_FORCE, TMW_RESET_VALUE);
      rdx(8'hC0, 8'h00);
      wr(TMW_OFS_MODE_CTRL, 8'hFF);
      rdx(TMW_OFS_MODE_CTRL, 8'hF3);
      wr(TMW_OFS_MODE_CTRL, 8'h00);
      wr(TMW_OFS_CLK_FORCE, 8'hC0);
      rdx(TMW_OFS_CLK_FORCE, 8'h00);
      wr(TMW_OFS_CMP_A, 8'h80);
      wr(TMW_OFS_CMP_B, 8'h80);
      wr(TMW_OFS_PIN_CTRL, 8'h03);
      // Clock stopped, so only the forced strobes move the waveform bits; pin A goes back to port_out_a once its output mode is 00
      for (int i = 0; i < 8; i++) begin
         wr(TMW_OFS_MODE_CTRL, 8'(fc[i % 4] << ((i < 4) ? 6 : 4)));
         wr(TMW_OFS_CLK_FORCE, (i < 4) ? 8'h80 : 8'h40);
         @(negedge mclk);
         chk({15'h0, (i < 4) ? level_a : level_b}, 16'(fe[i % 4]));
         @(posedge mclk);
      end
      @(negedge mclk);
      chk({15'h0, level_a}, 16'h1);
      @(posedge mclk);
      wr(TMW_OFS_PIN_CTRL, 8'h00);
      @(negedge mclk);
      chk({14'h0, pin_oe_n_a, pin_oe_n_b}, 16'h3);
      @(posedge mclk);
      wr(TMW_OFS_PIN_CTRL, 8'h03);
      // Mode order never passes through the two reserved codes
      for (int i = 0; i < 7; i++) begin
         wr(TMW_OFS_CMP_A, 8'(ca[i]));
         wr(TMW_OFS_CMP_B, 8'h20);
         wr(TMW_OFS_MODE_CTRL, 8'(cm[i] | (md[i] & 3)));
         wr(TMW_OFS_CLK_FORCE, 8'(((md[i] >> 2) << 3) | 1));
         repeat (600) @(posedge mclk);
         meas(wn[i]);
         chk(16'(nv), 16'(ov[i]));
         chk(16'(na), 16'(ha[i]));
         chk(16'(nb), 16'(hb[i]));
      end
      summarize();
   end
endmodule : tmw_timer_test
